// file: logic/asc_pkg.sv
// How it works
// - Startup wait 0..256 converter clocks by code
// - Startup wait also after deep sleep wake
// - Dither increments gap after each sample, wraps
// - Gap between samples equals gap field
// - Window mode selects compare condition
// - Sampling lasts two plus extension cycles
// - Channel change waits for conversion end
// - Channel codes decode to inputs and internals
// - Start bit starts, reads busy, self-clears
// - Writing zero to start bit aborts
// - Event starts conversion when enabled
// - Interrupt needs flag and enable both
// - Window checked at measurement end
// - Done flag set per new result
// - Flags clear by write-one or result read
// - Debug halt freezes unless run enabled
// - One shared byte buffer for 16-bit access
// - Low byte at base, high at base+1
// - Samples saturate to ten-bit range
// - Accumulate 1 to 64 samples by code
// - Truncate select drops two low bits
// - Converter clock divides by 2 to 256
// - Window applies to accumulated value only
`default_nettype none
package asc_pkg;
	// ==========================================
	// Register offsets
	localparam logic [4:0] OFS_CTRL_A    = 5'h00;
	localparam logic [4:0] OFS_ACCUM     = 5'h01;
	localparam logic [4:0] OFS_CLKDIV    = 5'h02;
	localparam logic [4:0] OFS_STARTUP   = 5'h03;
	localparam logic [4:0] OFS_WINMODE   = 5'h04;
	localparam logic [4:0] OFS_SAMPTIME  = 5'h05;
	localparam logic [4:0] OFS_CHANNEL   = 5'h06;
	localparam logic [4:0] OFS_COMMAND   = 5'h08;
	localparam logic [4:0] OFS_EVENT_TRIGGER_CTRL    = 5'h09;
	localparam logic [4:0] OFS_INTEN     = 5'h0A;
	localparam logic [4:0] OFS_INTERRUPT_FLAGS  = 5'h0B;
	localparam logic [4:0] OFS_DEBUG     = 5'h0C;
	localparam logic [4:0] OFS_BUFFER    = 5'h0D;
	localparam logic [4:0] OFS_RESULT    = 5'h10;
	localparam logic [4:0] OFS_WINLOW    = 5'h12;
	localparam logic [4:0] OFS_WINHIGH   = 5'h14;
	localparam logic [4:0] OFS_HI_STEP   = 5'h01;
	localparam logic [7:0] RESET_BYTE    = 8'h00;
	// ==========================================
	// Field positions
	localparam int BIT_ENABLE   = 0;
	localparam int BIT_TRUNC    = 2;
	localparam int BIT_DITHER   = 4;
	localparam int BIT_DONE     = 0;
	localparam int BIT_WIN      = 1;
	// ==========================================
	// Codes and counts
	localparam logic [2:0] WIN_NONE    = 3'h0;
	localparam logic [2:0] WIN_BELOW   = 3'h1;
	localparam logic [2:0] WIN_ABOVE   = 3'h2;
	localparam logic [2:0] WIN_INSIDE  = 3'h3;
	localparam logic [2:0] WIN_OUTSIDE = 3'h4;
	localparam logic [2:0] STARTUP_MAX = 3'h5;
	localparam logic [2:0] ACCUM_MAX   = 3'h6;
	localparam logic [8:0] STARTUP_UNIT = 9'h010;
	localparam logic [5:0] SAMPLE_BASE = 6'h02;
	localparam logic [9:0] SAMPLE_FULL = 10'h3FF;
	localparam logic [4:0] CH_EXT_LAST = 5'h0B;
	localparam logic [4:0] CH_INT_FIRST = 5'h1B;
	// Converter busy time for the successive approximation steps
	localparam logic [3:0] CONV_CYCLES = 4'hB;

	typedef enum logic [2:0] {ASC_IDLE, ASC_STARTUP, ASC_SAMPLE, ASC_CONVERT, ASC_GAP} asc_state_t;

	typedef struct packed {
		logic       valid;
		logic [4:0] addr;
		logic [7:0] data;
	} asc_wr_t;

	typedef struct packed {
		logic [4:0] channel;
		logic       channel_ok;
		logic       sample_open;
		logic       convert;
	} asc_front_t;
endpackage : asc_pkg
`default_nettype wire

// file: logic/asc_clkdiv.sv
`timescale 1ns/1ps
`default_nettype none
module asc_clkdiv (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	// Control
	input  wire logic       run,
	input  wire logic [2:0] div_sel,
	// Converter clock enable
	output logic            tick
);
	logic [7:0] count_reg;
	wire  [7:0] limit = 8'((9'h002 << div_sel) - 9'h001);

	// ==========================================
	// Divider
	assign tick = run && (count_reg >= limit);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) count_reg <= 8'h00;
		else if (!run || tick) count_reg <= 8'h00;
		else count_reg <= count_reg + 8'h01;
	end
endmodule : asc_clkdiv
`default_nettype wire

// file: logic/asc_word16.sv
`timescale 1ns/1ps
`default_nettype none
module asc_word16 (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// Commit
	input  wire logic        wr_en,
	input  wire logic [15:0] wr_data,
	// Value
	output logic [15:0]      value
);
	// ==========================================
	// Threshold storage, both bytes at once
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) value <= 16'h0000;
		else if (wr_en) value <= wr_data;
	end
endmodule : asc_word16
`default_nettype wire

// file: logic/asc_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module asc_sequencer (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// Register port
	input  wire logic [4:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [7:0]       reg_rdata,
	// System
	input  wire logic        start_event,
	input  wire logic        debug_halted,
	input  wire logic        deep_sleep_wake,
	input  wire logic        internal_ref_sel,
	// Front end
	input  wire logic [9:0]  sample_code,
	input  wire logic        sample_over,
	input  wire logic        sample_under,
	output asc_pkg::asc_front_t front,
	// Interrupt request
	output logic             irq
);
	// ==========================================
	// Registers
	logic [7:0]  ctrl_a_reg, accum_reg, clkdiv_reg, startup_reg, winmode_reg;
	logic [7:0]  samptime_reg, chan_reg, event_trigger_ctrl_reg, inten_reg, debug_reg, buf_reg;
	logic [1:0]  flags_reg;
	logic        busy_reg;
	logic [15:0] result_reg, acc_reg;
	logic [4:0]  active_ch_reg;
	logic [8:0]  cnt_reg;
	logic [6:0]  nsamp_reg;
	logic        enable_q_reg, intref_q_reg, wake_pend_reg;
	asc_pkg::asc_state_t state_reg;
	logic [7:0]  rdata_reg;
	logic [15:0] win_low, win_high;

	// ==========================================
	// Decode
	function automatic logic [8:0] startup_len(input logic [2:0] code);
		if (code == 3'h0 || code > asc_pkg::STARTUP_MAX) startup_len = 9'h000;
		else startup_len = 9'(asc_pkg::STARTUP_UNIT << (code - 3'h1));
	endfunction : startup_len

	function automatic logic hit(input logic [4:0] a, input logic [4:0] base);
		hit = (a == base) || (a == base + asc_pkg::OFS_HI_STEP);
	endfunction : hit

	wire       wr_cmd     = reg_wr && reg_addr == asc_pkg::OFS_COMMAND;
	wire       start_sw   = wr_cmd && reg_wdata[0];
	wire       abort_sw   = wr_cmd && !reg_wdata[0] && busy_reg;
	wire       halted     = debug_halted && !debug_reg[0];
	wire       start_ev   = start_event && event_trigger_ctrl_reg[0] && !halted;
	wire       enabled    = ctrl_a_reg[asc_pkg::BIT_ENABLE];
	wire       start_req  = enabled && !busy_reg && (start_sw || start_ev);
	// A zero-length wait skips the startup state instead of costing one tick
	wire [8:0] wait_len   = startup_len(startup_reg[7:5]);
	wire       use_wait   = wake_pend_reg && wait_len != 9'h000;
	wire       res_lo_rd  = reg_rd && reg_addr == asc_pkg::OFS_RESULT;
	wire       wr_hi_low  = reg_wr && reg_addr == asc_pkg::OFS_WINLOW + asc_pkg::OFS_HI_STEP;
	wire       wr_hi_high = reg_wr && reg_addr == asc_pkg::OFS_WINHIGH + asc_pkg::OFS_HI_STEP;
	wire       tick;
	wire       truncate   = ctrl_a_reg[asc_pkg::BIT_TRUNC];
	wire [2:0] acc_code   = accum_reg[2:0] > asc_pkg::ACCUM_MAX ? 3'h0 : accum_reg[2:0];
	wire [6:0] acc_total  = 7'(7'h01 << acc_code);
	wire [9:0] clipped    = sample_over ? asc_pkg::SAMPLE_FULL : sample_under ? 10'h000 : sample_code;
	wire [9:0] sample_val = truncate ? {2'h0, clipped[9:2]} : clipped;
	wire [15:0] acc_sum   = acc_reg + {6'h00, sample_val};
	wire       conv_end   = state_reg == asc_pkg::ASC_CONVERT && tick && cnt_reg == 9'h000;
	wire       last_samp  = nsamp_reg + 7'h01 >= acc_total;
	wire       meas_done  = conv_end && last_samp;
	wire       win_low_lt = acc_sum < win_low;
	wire       win_hi_gt  = acc_sum > win_high;
	logic      win_match;

	// Window on final accumulated value only
	always_comb begin
		case (winmode_reg[2:0])
			asc_pkg::WIN_BELOW:   win_match = win_low_lt;
			asc_pkg::WIN_ABOVE:   win_match = win_hi_gt;
			asc_pkg::WIN_INSIDE:  win_match = acc_sum > win_low && acc_sum < win_high;
			asc_pkg::WIN_OUTSIDE: win_match = win_low_lt || win_hi_gt;
			default:              win_match = 1'b0;
		endcase
	end

	asc_clkdiv u_div (
		.clk     (clk),
		.arst_n  (arst_n),
		.run     (busy_reg && !halted),
		.div_sel (clkdiv_reg[2:0]),
		.tick    (tick)
	);

	asc_word16 u_win_low (
		.clk     (clk),
		.arst_n  (arst_n),
		.wr_en   (wr_hi_low),
		.wr_data ({reg_wdata, buf_reg}),
		.value   (win_low)
	);

	asc_word16 u_win_high (
		.clk     (clk),
		.arst_n  (arst_n),
		.wr_en   (wr_hi_high),
		.wr_data ({reg_wdata, buf_reg}),
		.value   (win_high)
	);

	// ==========================================
	// Front end and interrupt
	wire ch_ok = active_ch_reg <= asc_pkg::CH_EXT_LAST || active_ch_reg >= asc_pkg::CH_INT_FIRST;
	assign front = '{channel: active_ch_reg, channel_ok: ch_ok,
		sample_open: state_reg == asc_pkg::ASC_SAMPLE || state_reg == asc_pkg::ASC_GAP,
		convert: state_reg == asc_pkg::ASC_CONVERT};
	assign irq = |(flags_reg & inten_reg[1:0]);
	assign reg_rdata = rdata_reg;

	// ==========================================
	// Plain control registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_a_reg   <= asc_pkg::RESET_BYTE;
			accum_reg    <= asc_pkg::RESET_BYTE;
			clkdiv_reg   <= asc_pkg::RESET_BYTE;
			winmode_reg  <= asc_pkg::RESET_BYTE;
			samptime_reg <= asc_pkg::RESET_BYTE;
			chan_reg     <= asc_pkg::RESET_BYTE;
			event_trigger_ctrl_reg   <= asc_pkg::RESET_BYTE;
			inten_reg    <= asc_pkg::RESET_BYTE;
			debug_reg    <= asc_pkg::RESET_BYTE;
		end else if (reg_wr) begin
			case (reg_addr)
				asc_pkg::OFS_CTRL_A:   ctrl_a_reg   <= reg_wdata & 8'h85;
				asc_pkg::OFS_ACCUM:    accum_reg    <= reg_wdata & 8'h07;
				asc_pkg::OFS_CLKDIV:   clkdiv_reg   <= reg_wdata & 8'h77;
				asc_pkg::OFS_WINMODE:  winmode_reg  <= reg_wdata & 8'h07;
				asc_pkg::OFS_SAMPTIME: samptime_reg <= reg_wdata & 8'h1F;
				asc_pkg::OFS_CHANNEL:  chan_reg     <= reg_wdata & 8'h1F;
				asc_pkg::OFS_EVENT_TRIGGER_CTRL:   event_trigger_ctrl_reg   <= reg_wdata & 8'h01;
				asc_pkg::OFS_INTEN:    inten_reg    <= reg_wdata & 8'h03;
				asc_pkg::OFS_DEBUG:    debug_reg    <= reg_wdata & 8'h01;
				default: ;
			endcase
		end
	end

	// ==========================================
	// Shared buffer and read data
	logic [7:0] rd_mux;
	always_comb begin
		case (reg_addr)
			asc_pkg::OFS_CTRL_A:   rd_mux = ctrl_a_reg;
			asc_pkg::OFS_ACCUM:    rd_mux = accum_reg;
			asc_pkg::OFS_CLKDIV:   rd_mux = clkdiv_reg;
			asc_pkg::OFS_STARTUP:  rd_mux = startup_reg;
			asc_pkg::OFS_WINMODE:  rd_mux = winmode_reg;
			asc_pkg::OFS_SAMPTIME: rd_mux = samptime_reg;
			asc_pkg::OFS_CHANNEL:  rd_mux = chan_reg;
			asc_pkg::OFS_COMMAND:  rd_mux = {7'h00, busy_reg};
			asc_pkg::OFS_EVENT_TRIGGER_CTRL:   rd_mux = event_trigger_ctrl_reg;
			asc_pkg::OFS_INTEN:    rd_mux = inten_reg;
			asc_pkg::OFS_INTERRUPT_FLAGS: rd_mux = {6'h00, flags_reg};
			asc_pkg::OFS_DEBUG:    rd_mux = debug_reg;
			asc_pkg::OFS_BUFFER:   rd_mux = buf_reg;
			asc_pkg::OFS_RESULT:   rd_mux = result_reg[7:0];
			asc_pkg::OFS_WINLOW:   rd_mux = win_low[7:0];
			asc_pkg::OFS_WINHIGH:  rd_mux = win_high[7:0];
			default:               rd_mux = hit(reg_addr, asc_pkg::OFS_RESULT) || hit(reg_addr, asc_pkg::OFS_WINLOW)
				|| hit(reg_addr, asc_pkg::OFS_WINHIGH) ? buf_reg : 8'h00;
		endcase
	end

	// Low-byte read latches the high byte so the pair stays coherent
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			buf_reg   <= asc_pkg::RESET_BYTE;
			rdata_reg <= asc_pkg::RESET_BYTE;
		end else begin
			rdata_reg <= reg_rd ? rd_mux : 8'h00;
			if (reg_wr && (reg_addr == asc_pkg::OFS_BUFFER || reg_addr == asc_pkg::OFS_WINLOW
				|| reg_addr == asc_pkg::OFS_WINHIGH))
				buf_reg <= reg_wdata;
			else if (res_lo_rd) buf_reg <= result_reg[15:8];
			else if (reg_rd && reg_addr == asc_pkg::OFS_WINLOW) buf_reg <= win_low[15:8];
			else if (reg_rd && reg_addr == asc_pkg::OFS_WINHIGH) buf_reg <= win_high[15:8];
		end
	end

	// ==========================================
	// Flags: set wins over clear
	wire [1:0] clr = (reg_wr && reg_addr == asc_pkg::OFS_INTERRUPT_FLAGS ? reg_wdata[1:0] : 2'b00)
		| {2{res_lo_rd}};
	wire [1:0] set = {meas_done && win_match, meas_done};

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) flags_reg <= 2'b00;
		else flags_reg <= (flags_reg & ~clr) | set;
	end

	// ==========================================
	// Startup and gap control, wake tracking
	wire wake_trig = enabled && (!enable_q_reg || (internal_ref_sel && !intref_q_reg) || deep_sleep_wake);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			startup_reg   <= asc_pkg::RESET_BYTE;
			enable_q_reg  <= 1'b0;
			intref_q_reg  <= 1'b0;
			wake_pend_reg <= 1'b0;
		end else begin
			enable_q_reg <= enabled;
			intref_q_reg <= internal_ref_sel;
			if (reg_wr && reg_addr == asc_pkg::OFS_STARTUP) startup_reg <= reg_wdata;
			else if (conv_end && startup_reg[asc_pkg::BIT_DITHER])
				startup_reg[3:0] <= startup_reg[3:0] + 4'h1;
			if (wake_trig) wake_pend_reg <= 1'b1;
			else if (start_req) wake_pend_reg <= 1'b0;
		end
	end

	// ==========================================
	// Sequencer
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg     <= asc_pkg::ASC_IDLE;
			busy_reg      <= 1'b0;
			cnt_reg       <= 9'h000;
			nsamp_reg     <= 7'h00;
			acc_reg       <= 16'h0000;
			result_reg    <= 16'h0000;
			active_ch_reg <= 5'h00;
		end else if (abort_sw || !enabled) begin
			state_reg <= asc_pkg::ASC_IDLE;
			busy_reg  <= 1'b0;
		end else if (start_req) begin
			busy_reg      <= 1'b1;
			active_ch_reg <= chan_reg[4:0];
			nsamp_reg     <= 7'h00;
			acc_reg       <= 16'h0000;
			state_reg     <= use_wait ? asc_pkg::ASC_STARTUP : asc_pkg::ASC_SAMPLE;
			cnt_reg       <= use_wait ? wait_len - 9'h001 : 9'({1'b0, samptime_reg[4:0]}
				+ asc_pkg::SAMPLE_BASE) - 9'h001;
		end else if (tick) begin
			case (state_reg)
				asc_pkg::ASC_STARTUP, asc_pkg::ASC_SAMPLE, asc_pkg::ASC_GAP: begin
					if (cnt_reg != 9'h000) cnt_reg <= cnt_reg - 9'h001;
					else if (state_reg == asc_pkg::ASC_SAMPLE) begin
						state_reg <= asc_pkg::ASC_CONVERT;
						cnt_reg   <= 9'(asc_pkg::CONV_CYCLES);
					end else begin
						state_reg <= asc_pkg::ASC_SAMPLE;
						cnt_reg   <= 9'({1'b0, samptime_reg[4:0]} + asc_pkg::SAMPLE_BASE) - 9'h001;
					end
				end
				asc_pkg::ASC_CONVERT: begin
					if (cnt_reg != 9'h000) cnt_reg <= cnt_reg - 9'h001;
					else if (last_samp) begin
						result_reg <= acc_sum;
						busy_reg   <= 1'b0;
						state_reg  <= asc_pkg::ASC_IDLE;
					end else begin
						acc_reg   <= acc_sum;
						nsamp_reg <= nsamp_reg + 7'h01;
						if (startup_reg[3:0] == 4'h0) begin
							state_reg <= asc_pkg::ASC_SAMPLE;
							cnt_reg   <= 9'({1'b0, samptime_reg[4:0]} + asc_pkg::SAMPLE_BASE) - 9'h001;
						end else begin
							state_reg <= asc_pkg::ASC_GAP;
							cnt_reg   <= {5'h00, startup_reg[3:0]} - 9'h001;
						end
					end
				end
				default: state_reg <= asc_pkg::ASC_IDLE;
			endcase
		end
	end
endmodule : asc_sequencer
`default_nettype wire

// file: tb/asc_sequencer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module asc_sequencer_monitor (
	// Clock and reset
	input wire logic                clk,
	input wire logic                arst_n,
	// Register port
	input wire logic [4:0]          reg_addr,
	input wire logic [7:0]          reg_wdata,
	input wire logic                reg_wr,
	input wire logic                reg_rd,
	input wire logic [7:0]          reg_rdata,
	// Front end and interrupt
	input wire asc_pkg::asc_front_t front,
	input wire logic                irq
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	wire logic busy_rd;
	assign busy_rd = reg_rd && reg_addr == asc_pkg::OFS_COMMAND && (front.sample_open || front.convert);
	// ==========================================
	// Channel and phases
	chan_hold_a: assert property (front.convert && $past(front.convert) |-> $stable(front.channel))
		else $error("channel moved during conversion");
	chan_decode_a: assert property (front.channel_ok == (front.channel <= asc_pkg::CH_EXT_LAST
		|| front.channel >= asc_pkg::CH_INT_FIRST)) else $error("channel decode wrong");
	samp_min_a: assert property ($rose(front.sample_open) |-> front.sample_open [*2])
		else $error("sampling phase too short");
	phase_excl_a: assert property (!(front.sample_open && front.convert))
		else $error("sampling and converting together");
	samp_to_conv_a: assert property ($fell(front.sample_open) |-> front.convert || $past(reg_wr))
		else $error("sampling ended without conversion");
	conv_min_a: assert property ($rose(front.convert) |-> front.convert [*8])
		else $error("conversion phase too short");
	// ==========================================
	// Status and interrupt
	busy_read_a: assert property (busy_rd |=> reg_rdata == 8'h01)
		else $error("start bit not read as busy");
	irq_mask_a: assert property (reg_wr && reg_addr == asc_pkg::OFS_INTEN && reg_wdata[1:0] == 2'b00
		|=> !irq) else $error("interrupt while disabled");
	irq_cause_a: assert property ($rose(irq) |-> $past(front.convert) || $past(reg_wr))
		else $error("interrupt without completion");
	cover property ($rose(front.convert));
	cover property ($rose(irq));
	cover property (busy_rd);
endmodule : asc_sequencer_monitor
bind asc_sequencer asc_sequencer_monitor u_mon (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .front(front), .irq(irq));
`default_nettype wire

// file: tb/asc_front_model.sv
`timescale 1ns/1ps
`default_nettype none
module asc_front_model (
	// From the sequencer
	input  wire asc_pkg::asc_front_t front,
	// Test controls
	input  wire logic                over_req,
	input  wire logic                under_req,
	// To the sequencer
	output logic [9:0]               sample_code,
	output logic                     sample_over,
	output logic                     sample_under
);
	// ==========================================
	// Channel dependent level
	wire logic [9:0] level;
	assign level = {front.channel, 5'h05};
	// Outside conversion the code is inverted so a mistimed capture shows
	assign sample_code = front.convert ? level : ~level;
	assign sample_over = front.convert & over_req;
	assign sample_under = front.convert & under_req;
endmodule : asc_front_model
`default_nettype wire

// file: tb/test_adc_sequencer_control.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module test_adc_sequencer_control;
	logic                clk = 1'b0;
	logic                arst_n = 1'b0;
	logic [4:0]          reg_addr = 5'h00;
	logic [7:0]          reg_wdata = 8'h00;
	logic                reg_wr = 1'b0;
	logic                reg_rd = 1'b0;
	logic                start_event = 1'b0;
	logic                debug_halted = 1'b0;
	logic                over_req = 1'b0;
	logic                under_req = 1'b0;
	logic                deep_sleep_wake = 1'b0;
	logic                internal_ref_sel = 1'b0;
	logic [7:0]          reg_rdata;
	logic [9:0]          sample_code;
	logic                sample_over;
	logic                sample_under;
	asc_pkg::asc_front_t front;
	logic                irq;
	logic [15:0]         res;
	logic [1:0]          win_exp [5] = '{2'b01, 2'b11, 2'b01, 2'b01, 2'b11};
	int                  error_cnt = 0;
	int                  n_tests = 0;
	int                  t0;
	int                  t1;
	always #2 clk = ~clk;
	asc_sequencer dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .start_event(start_event), .debug_halted(debug_halted),
		.deep_sleep_wake(deep_sleep_wake), .internal_ref_sel(internal_ref_sel), .sample_code(sample_code),
		.sample_over(sample_over),
		.sample_under(sample_under), .front(front), .irq(irq));
	asc_front_model u_front (.front(front), .over_req(over_req), .under_req(under_req),
		.sample_code(sample_code), .sample_over(sample_over), .sample_under(sample_under));
	// ==========================================
	// Bus tasks
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		// Data stand for the cycle after the strobe; taken at its closing edge
		@(posedge clk);
		d = reg_rdata;
	endtask : rd
	task automatic chk_rd(input string nm, input logic [4:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		`CHK(nm, e, d)
	endtask : chk_rd
	task automatic kick;
		@(posedge clk);
		start_event <= 1'b1;
		@(posedge clk);
		start_event <= 1'b0;
	endtask : kick
	task automatic wake_pulse;
		deep_sleep_wake <= 1'b1;
		@(posedge clk);
		deep_sleep_wake <= 1'b0;
	endtask : wake_pulse
	// Cycles from start to done; differences cancel the bench latency
	task automatic timed(output int n);
		n = 0;
		wr(asc_pkg::OFS_COMMAND, 8'h01);
		while (irq !== 1'b1 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		wr(asc_pkg::OFS_INTERRUPT_FLAGS, 8'h03);
	endtask : timed
	// Long accumulations need the wide bound
	task automatic fetch(output logic [15:0] r);
		logic [7:0] lo;
		logic [7:0] hi;
		for (int i = 0; i < 5000 && irq !== 1'b1; i++) @(posedge clk);
		`CHK("irq", 1'b1, irq)
		rd(asc_pkg::OFS_RESULT, lo);
		rd(asc_pkg::OFS_RESULT + asc_pkg::OFS_HI_STEP, hi);
		r = {hi, lo};
	endtask : fetch
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		#200000;
		error_cnt++;
		tally_and_finish();
	end
	// ==========================================
	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		for (int a = 0; a < 22; a++) chk_rd("reset", 5'(a), 8'h00);
		wr(asc_pkg::OFS_SAMPTIME, 8'h1F);
		chk_rd("samptime", asc_pkg::OFS_SAMPTIME, 8'h1F);
		wr(asc_pkg::OFS_SAMPTIME, 8'h00);
		wr(asc_pkg::OFS_BUFFER, 8'hA5);
		chk_rd("buffer", asc_pkg::OFS_BUFFER, 8'hA5);
		wr(asc_pkg::OFS_WINHIGH, 8'h00);
		chk_rd("held low", asc_pkg::OFS_BUFFER, 8'h00);
		wr(asc_pkg::OFS_WINHIGH + 5'h01, 8'h01);
		chk_rd("win low", asc_pkg::OFS_WINHIGH, 8'h00);
		chk_rd("latched", asc_pkg::OFS_BUFFER, 8'h01);
		wr(asc_pkg::OFS_WINLOW, 8'h50);
		wr(asc_pkg::OFS_WINLOW + 5'h01, 8'h00);
		wr(asc_pkg::OFS_CTRL_A, 8'h01);
		wr(asc_pkg::OFS_CHANNEL, 8'h02);
		wr(asc_pkg::OFS_INTEN, 8'h01);
		for (int m = 0; m < 5; m++) begin
			wr(asc_pkg::OFS_WINMODE, 8'(m));
			wr(asc_pkg::OFS_COMMAND, 8'h01);
			chk_rd("busy", asc_pkg::OFS_COMMAND, 8'h01);
			for (int i = 0; i < 500 && irq !== 1'b1; i++) @(posedge clk);
			chk_rd("flags", asc_pkg::OFS_INTERRUPT_FLAGS, {6'h00, win_exp[m]});
			wr(asc_pkg::OFS_INTERRUPT_FLAGS, 8'h00);
			chk_rd("kept", asc_pkg::OFS_INTERRUPT_FLAGS, {6'h00, win_exp[m]});
			wr(asc_pkg::OFS_INTERRUPT_FLAGS, 8'h03);
			chk_rd("cleared", asc_pkg::OFS_INTERRUPT_FLAGS, 8'h00);
			chk_rd("done", asc_pkg::OFS_COMMAND, 8'h00);
			`CHK("irq off", 1'b0, irq)
		end
		wr(asc_pkg::OFS_WINMODE, 8'h00);
		wr(asc_pkg::OFS_COMMAND, 8'h01);
		wr(asc_pkg::OFS_CHANNEL, 8'h03);
		fetch(res);
		`CHK("old channel", 16'h0045, res)
		chk_rd("read clears", asc_pkg::OFS_INTERRUPT_FLAGS, 8'h00);
		wr(asc_pkg::OFS_COMMAND, 8'h01);
		fetch(res);
		`CHK("new channel", 16'h0065, res)
		over_req <= 1'b1;
		wr(asc_pkg::OFS_ACCUM, 8'h01);
		wr(asc_pkg::OFS_COMMAND, 8'h01);
		fetch(res);
		`CHK("acc2 full", 16'h07FE, res)
		wr(asc_pkg::OFS_ACCUM, 8'h06);
		wr(asc_pkg::OFS_COMMAND, 8'h01);
		fetch(res);
		`CHK("acc64 full", 16'hFFC0, res)
		wr(asc_pkg::OFS_ACCUM, 8'h00);
		wr(asc_pkg::OFS_CTRL_A, 8'h05);
		wr(asc_pkg::OFS_COMMAND, 8'h01);
		fetch(res);
		`CHK("truncated", 16'h00FF, res)
		over_req <= 1'b0;
		under_req <= 1'b1;
		wr(asc_pkg::OFS_CTRL_A, 8'h01);
		wr(asc_pkg::OFS_STARTUP, 8'h1F);
		wr(asc_pkg::OFS_COMMAND, 8'h01);
		fetch(res);
		`CHK("floor", 16'h0000, res)
		chk_rd("dither wrap", asc_pkg::OFS_STARTUP, 8'h10);
		under_req <= 1'b0;
		wr(asc_pkg::OFS_STARTUP, 8'h00);
		wr(asc_pkg::OFS_COMMAND, 8'h01);
		for (int i = 0; i < 200 && front.convert !== 1'b1; i++) @(posedge clk);
		repeat (10) @(posedge clk);
		wr(asc_pkg::OFS_COMMAND, 8'h00);
		repeat (100) @(posedge clk);
		chk_rd("aborted", asc_pkg::OFS_INTERRUPT_FLAGS, 8'h00);
		chk_rd("stopped", asc_pkg::OFS_COMMAND, 8'h00);
		wr(asc_pkg::OFS_EVENT_TRIGGER_CTRL, 8'h01);
		debug_halted <= 1'b1;
		kick();
		repeat (200) @(posedge clk);
		`CHK("halted", 1'b0, irq)
		wr(asc_pkg::OFS_DEBUG, 8'h01);
		kick();
		fetch(res);
		`CHK("event", 16'h0065, res)
		debug_halted <= 1'b0;
		timed(t0);
		wr(asc_pkg::OFS_SAMPTIME, 8'h05);
		timed(t1);
		`CHK("sample ext", 10, t1 - t0)
		wr(asc_pkg::OFS_SAMPTIME, 8'h00);
		wr(asc_pkg::OFS_CLKDIV, 8'h01);
		timed(t1);
		`CHK("divider", 28, t1 - t0)
		wr(asc_pkg::OFS_CLKDIV, 8'h00);
		wr(asc_pkg::OFS_ACCUM, 8'h01);
		wr(asc_pkg::OFS_STARTUP, 8'h03);
		timed(t1);
		`CHK("gap", 34, t1 - t0)
		wr(asc_pkg::OFS_ACCUM, 8'h00);
		wr(asc_pkg::OFS_STARTUP, 8'h20);
		wake_pulse();
		timed(t1);
		`CHK("wake wait", 32, t1 - t0)
		wr(asc_pkg::OFS_STARTUP, 8'h40);
		internal_ref_sel <= 1'b1;
		timed(t1);
		`CHK("ref wait", 64, t1 - t0)
		wr(asc_pkg::OFS_STARTUP, 8'hE0);
		wake_pulse();
		timed(t1);
		`CHK("reserved wait", 0, t1 - t0)
		wr(asc_pkg::OFS_INTEN, 8'h00);
		wr(asc_pkg::OFS_COMMAND, 8'h01);
		repeat (60) @(posedge clk);
		chk_rd("done no irq", asc_pkg::OFS_INTERRUPT_FLAGS, 8'h01);
		`CHK("irq masked", 1'b0, irq)
		tally_and_finish();
	end
endmodule : test_adc_sequencer_control
`default_nettype wire
